//--- cfg_chk_sva.sv
`timescale 1ns/1ps
module cfg_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // inputs
   input wire logic full_width_write,
   input wire logic bootstrap_processor_flag,
   input wire logic [2:0] platform_flag,
   input wire logic reg_read,
   input wire logic reg_write,
   input wire logic [7:0] reg_index,
   input wire logic [63:0] reg_wdata,
   input wire logic stamp_read,
   // outputs
   input wire logic [63:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic intr_ctrl_enable,
   input wire logic [19:0] intr_ctrl_base
);
   logic [63:0] wd_q [3];
   wire rd = reg_read & !stamp_read;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge ref_clk) begin
      wd_q[0] <= reg_wdata;
      wd_q[1] <= wd_q[0];
      wd_q[2] <= wd_q[1];
   end
   sequence s_st; stamp_read && !reg_write; endsequence
   sequence s_cw(f); reg_write && reg_index == 8'h10 && full_width_write == f; endsequence
   property p_st; s_st ##2 s_st |=> reg_hit && reg_rdata == $past(reg_rdata, 2) + 64'h2; endproperty
   a_st: assert property (p_st) else $error("stamp step");
   property p_lo; s_cw(0) ##2 s_st |=> reg_rdata == {32'h0, wd_q[2][31:0]} + 64'h1; endproperty
   a_lo: assert property (p_lo) else $error("low write");
   property p_fu; s_cw(1) ##2 s_st |=> reg_rdata == wd_q[2] + 64'h1; endproperty
   a_fu: assert property (p_fu) else $error("full write");
   property p_pl; rd && reg_index == 8'h17 |=> reg_hit && reg_rdata == {11'h0, platform_flag, 50'h0}; endproperty
   a_pl: assert property (p_pl) else $error("platform");
   property p_ib; rd && reg_index == 8'h1B |=> reg_rdata == {32'h0, $past(intr_ctrl_base),
      $past(intr_ctrl_enable), 2'h0, bootstrap_processor_flag, 8'h0}; endproperty
   a_ib: assert property (p_ib) else $error("base read");
   property p_iw; reg_write && reg_index == 8'h1B |=> intr_ctrl_enable == wd_q[0][11] && intr_ctrl_base == wd_q[0][31:12];
   endproperty
   a_iw: assert property (p_iw) else $error("base write");
   property p_um; rd && !(reg_index inside {8'h10, 8'h17, 8'h1B, 8'h2A}) |=> !reg_hit && reg_rdata == 64'h0; endproperty
   a_um: assert property (p_um) else $error("unmapped");
   property p_hp; rd && reg_index == 8'h2A |=> reg_hit && reg_rdata[63:1] == 63'h0; endproperty
   a_hp: assert property (p_hp) else $error("power-on");
endmodule
bind processor_config_model_regs cfg_chk cfg_chk_i (.*);

//--- model_regs_pkg.sv
package model_regs_pkg;
   // register indices as seen by the special register instructions
   localparam logic [7:0] stamp_counter_idx = 8'h10;
   localparam logic [7:0] platform_id_idx = 8'h17;
   localparam logic [7:0] intr_base_idx = 8'h1B;
   localparam logic [7:0] hard_poweron_idx = 8'h2A;

   // field positions
   localparam int platform_flag_lsb = 50;
   localparam int platform_flag_msb = 52;
   localparam int boot_flag_bit = 8;
   localparam int intr_enable_bit = 11;
   localparam int intr_base_lsb = 12;
   localparam int intr_base_msb = 31;
   localparam int tristate_strap_bit = 0;
   localparam int half_width = 32;

   // values after reset
   localparam logic [63:0] stamp_reset = 64'h0;
   localparam logic intr_enable_reset = 1'b1;
   localparam logic [19:0] intr_base_reset = 20'hFEE00;
   localparam logic [1:0] strap_sync_reset = 2'h0;
   // clocks after reset release until the synchroniser holds a fresh pin sample
   localparam logic [1:0] strap_fill_cycles = 2'h2;

   // default platform flag; arbitrary value
   localparam logic [2:0] platform_flag_default = 3'h0;
endpackage

//--- processor_config_model_regs.sv
`timescale 1ns/1ps
// How it works
// - 64-bit stamp counter read returns full count
// - legacy: low-half write clears upper half
// - newer variant: all 64 bits writable
// - platform register read-only, flag at 52:50
// - bit 8 shows bootstrap processor flag
// - bit 11 globally enables interrupt controller
// - bits 31:12 hold controller base address
// - power-on register holds only read-only status bits
// - bit 0 reports tristate strap pin
// - strap bits captured on the third clock after reset release
// - strap bit reads 1 when pin asserted
module processor_config_model_regs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // static configuration
   input wire logic full_width_write,
   input wire logic bootstrap_processor_flag,
   input wire logic [2:0] platform_flag,
   // strap pin, active low on the bus
   input wire logic system_mgmt_interrupt_pin_n,
   // special register access
   input wire logic reg_read,
   input wire logic reg_write,
   input wire logic [7:0] reg_index,
   input wire logic [63:0] reg_wdata,
   input wire logic stamp_read,
   output logic [63:0] reg_rdata,
   output logic reg_hit,
   // controls to the interrupt controller
   output logic intr_ctrl_enable,
   output logic [19:0] intr_ctrl_base
);
   import model_regs_pkg::*;

   // ==================================================
   // state
   typedef struct packed {
      logic [63:0] stamp;
      logic intr_enable;
      logic [19:0] intr_base;
      logic [63:0] rdata;
      logic hit;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic tristate_strap;
   logic strap_level;
   logic [63:0] platform_word;
   logic [63:0] intr_word;
   logic [63:0] poweron_word;

   // ==================================================
   // strap capture
   // the raw pin goes straight into the synchroniser; it is asserted low, so the held level is inverted
   strap_capture u_tristate (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .strap_pin(system_mgmt_interrupt_pin_n),
      .strap_value(strap_level)
   );
   assign tristate_strap = !strap_level;

   // ==================================================
   // read words
   always_comb begin
      platform_word = 64'h0;
      platform_word[platform_flag_msb:platform_flag_lsb] = platform_flag;
      intr_word = 64'h0;
      intr_word[boot_flag_bit] = bootstrap_processor_flag;
      intr_word[intr_enable_bit] = s_q.intr_enable;
      intr_word[intr_base_msb:intr_base_lsb] = s_q.intr_base;
      // only the read-only strap status lives here; no writable bits are defined yet
      poweron_word = 64'h0;
      poweron_word[tristate_strap_bit] = tristate_strap;
   end

   // ==================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.stamp = s_q.stamp + 64'h1;
      s_d.hit = 1'b0;
      if (reg_write) begin
         unique case (reg_index)
            stamp_counter_idx: begin
               if (full_width_write) begin
                  s_d.stamp = reg_wdata;
               end else begin
                  s_d.stamp = {32'h0, reg_wdata[half_width-1:0]};
               end
            end
            intr_base_idx: begin
               s_d.intr_enable = reg_wdata[intr_enable_bit];
               s_d.intr_base = reg_wdata[intr_base_msb:intr_base_lsb];
            end
            default: begin
               // read-only and unmapped indices ignore writes
               s_d.intr_enable = s_q.intr_enable;
            end
         endcase
      end
      if (stamp_read) begin
         s_d.rdata = s_q.stamp;
         s_d.hit = 1'b1;
      end else if (reg_read) begin
         s_d.hit = 1'b1;
         unique case (reg_index)
            stamp_counter_idx: s_d.rdata = s_q.stamp;
            platform_id_idx: s_d.rdata = platform_word;
            intr_base_idx: s_d.rdata = intr_word;
            hard_poweron_idx: s_d.rdata = poweron_word;
            default: begin
               s_d.rdata = 64'h0;
               s_d.hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q.stamp <= stamp_reset;
         s_q.intr_enable <= intr_enable_reset;
         s_q.intr_base <= intr_base_reset;
         s_q.rdata <= 64'h0;
         s_q.hit <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign reg_hit = s_q.hit;
   assign intr_ctrl_enable = s_q.intr_enable;
   assign intr_ctrl_base = s_q.intr_base;
endmodule

//--- processor_config_model_regs_test.sv
`timescale 1ns/1ps
module processor_config_model_regs_test;
   import model_regs_pkg::*;
   logic ref_clk = 0, arst_n = 0, full_w = 0, rd = 0, wr = 0, st = 0, pin_n = 0, hit, en;
   logic [7:0] idx = 8'h0;
   logic [63:0] wd = 64'h0, rdata, v;
   logic [19:0] base;
   int fail_count = 0, n_compared = 0, cyc = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t got %h", $time, a); end end
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         fail_count++;
         summarize();
      end
   end
   processor_config_model_regs processor_config_model_regs_i (.ref_clk(ref_clk), .arst_n(arst_n),
      .full_width_write(full_w), .bootstrap_processor_flag(1'b1), .platform_flag(3'h5),
      .system_mgmt_interrupt_pin_n(pin_n), .reg_read(rd), .reg_write(wr), .reg_index(idx), .reg_wdata(wd),
      .stamp_read(st), .reg_rdata(rdata), .reg_hit(hit), .intr_ctrl_enable(en), .intr_ctrl_base(base));
   // ==================================================
   // one request, answer sampled after its edge settles
   task automatic op(input logic r, w, s, input logic [7:0] i, input logic [63:0] d);
      @(posedge ref_clk);
      rd <= r; wr <= w; st <= s; idx <= i; wd <= d;
      @(posedge ref_clk);
      rd <= 0; wr <= 0; st <= 0;
      #1;
   endtask
   task automatic t_base;
      op(1, 0, 0, 8'h1B, 0);
      `CHK(rdata, {32'h0, intr_base_reset, intr_enable_reset, 3'h1, 8'h0})
      op(0, 1, 0, 8'h1B, 64'hFFFF_FFFF_FFFF_F7FF);
      `CHK({en, base}, 21'h0FFFFF)
      op(1, 0, 0, 8'h1B, 0);
      `CHK(rdata, 64'hFFFF_F100)
   endtask
   task automatic t_ro;
      op(0, 1, 0, 8'h17, '1);
      op(0, 1, 0, 8'h2A, '1);
      op(1, 0, 0, 8'h17, 0);
      `CHK(rdata, {11'h0, 3'h5, 50'h0})
      op(1, 0, 0, 8'h2A, 0);
      `CHK(rdata, 64'h1)
      op(1, 0, 0, 8'h33, 0);
      `CHK({hit, rdata}, 65'h0)
   endtask
   task automatic t_count;
      op(0, 1, 0, 8'h10, 64'hAAAA_AAAA_FFFF_FFFF);
      op(0, 0, 1, 8'h33, 0);
      `CHK(rdata, 64'h1_0000_0000)
      v = rdata;
      op(0, 0, 1, 8'h10, 0);
      `CHK(rdata, v + 64'h2)
      @(posedge ref_clk);
      full_w <= 1;
      op(0, 1, 0, 8'h10, 64'hFFFF_FFFF_FFFF_FFFE);
      op(0, 0, 1, 8'h10, 0);
      `CHK(rdata, 64'hFFFF_FFFF_FFFF_FFFF)
      op(1, 0, 0, 8'h10, 0);
      `CHK({hit, rdata}, 65'h1_0000_0000_0000_0001)
   endtask
   task automatic summarize;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      // strap held asserted across reset release
      repeat (2) @(posedge ref_clk);
      arst_n <= 1;
      t_base();
      t_ro();
      t_count();
      summarize();
   end
endmodule

//--- strap_capture.sv
`timescale 1ns/1ps
// holds a pin strap value taken on the third clock after reset release
module strap_capture (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // pin and captured value
   input wire logic strap_pin,
   output logic strap_value
);
   import model_regs_pkg::*;

   typedef struct packed {
      logic [1:0] sync;
      logic [1:0] count;
      logic taken;
      logic value;
   } state_type;

   state_type s_q;
   state_type s_d;

   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[0], strap_pin};
      // value is caught once, only after the synchroniser has refilled from the pin;
      // catching earlier would report the reset content of the flops instead of the strap
      if (!s_q.taken) begin
         if (s_q.count == strap_fill_cycles) begin
            s_d.value = s_q.sync[1];
            s_d.taken = 1'b1;
         end else begin
            s_d.count = s_q.count + 2'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign strap_value = s_q.value;
endmodule
